// >>> spm_pkg.sv
`default_nettype none
package spm_pkg;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int          FRAME_W   = 24;
   localparam int          OP_HI     = 23;
   localparam int          OP_LO     = 16;
   localparam logic [7:0]  OP_SLEEP  = 8'h03;
   localparam logic [7:0]  OP_STATUS = 8'h00;

   // ----------------------------------------------------------------
   // Switch inputs
   // ----------------------------------------------------------------
   localparam int          SW_G_W    = 14;
   localparam int          SW_P_W    = 8;
   localparam int          SW_W      = SW_G_W + SW_P_W;

   // ----------------------------------------------------------------
   // Wake source codes
   // ----------------------------------------------------------------
   localparam logic [1:0]  SRC_NONE   = 2'h0;
   localparam logic [1:0]  SRC_SPI    = 2'h1;
   localparam logic [1:0]  SRC_SWITCH = 2'h2;
   localparam logic [1:0]  SRC_LINE   = 2'h3;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          CLK_NS          = 40;
   localparam int          WAKE_SETTLE_NS  = 200;
   localparam logic [3:0]  WAKE_SETTLE_CYC = 4'((WAKE_SETTLE_NS + CLK_NS - 1) / CLK_NS);

   typedef enum logic [1:0] {
      SPM_NORMAL = 2'b01,
      SPM_SLEEP  = 2'b10
   } spm_mode_e;

endpackage : spm_pkg
`default_nettype wire

// >>> spm_sleep_wake.sv
`default_nettype none
module spm_sleep_wake
   import spm_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              srst_i,
   input  wire logic              spi_sclk_i,
   input  wire logic              spi_cs_n_i,
   input  wire logic              spi_mosi_i,
   output var  logic              spi_miso_o,
   input  wire logic [SW_G_W-1:0] ground_switch_input_i,
   input  wire logic [SW_P_W-1:0] programmable_switch_input_i,
   input  wire logic              wake_n_i,
   output var  logic              wake_n_o,
   output var  logic              wake_oe_n_o,
   input  wire logic              logic_supply_ok_i,
   input  wire logic              por_trip_i,
   output var  logic              sleep_o,
   output var  logic              int_flag_o,
   output var  logic [1:0]        wake_src_o
);

   // ----------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [FRAME_W-1:0] shreg;
   } spm_link_s;

   typedef struct packed {
      logic            cs_s1;
      logic            cs_s2;
      logic            cs_s3;
      logic            wk_s1;
      logic            wk_s2;
      logic            sup_s1;
      logic            sup_s2;
      logic            por_s1;
      logic            por_s2;
      logic [SW_W-1:0] sw_s1;
      logic [SW_W-1:0] sw_s2;
      logic [SW_W-1:0] sw_s3;
      spm_mode_e       mode;
      logic            race;
      logic [3:0]      settle;
      logic            int_flag;
      logic [1:0]      src;
      logic            sleep;
      logic            drv_oe_n;
   } spm_ref_s;

   spm_link_s lnk_r;
   spm_link_s lnk_nxt;
   spm_ref_s  st_r;
   spm_ref_s  st_nxt;

   function automatic logic is_op(input logic [FRAME_W-1:0] frame,
                                  input logic [7:0]         op);
      return frame[OP_HI:OP_LO] == op;
   endfunction : is_op

   // ----------------------------------------------------------------
   // Link domain
   // ----------------------------------------------------------------
   // Each clock moves the frame one place on, so the oldest bit reaches
   // the next device in the chain and only the last 24 bits stay here.
   always_comb begin
      lnk_nxt       = lnk_r;
      lnk_nxt.shreg = {lnk_r.shreg[FRAME_W-2:0], spi_mosi_i};
   end

   always_ff @(posedge spi_sclk_i) begin
      lnk_r <= lnk_nxt;
   end

   assign spi_miso_o = lnk_r.shreg[FRAME_W-1];

   // ----------------------------------------------------------------
   // Events seen in the reference domain
   // ----------------------------------------------------------------
   logic cs_fall;
   logic cs_rise;
   logic sw_chg;
   logic op_sleep;
   logic op_status;
   logic line_low;

   assign cs_fall   = st_r.cs_s3 & ~st_r.cs_s2;
   assign cs_rise   = ~st_r.cs_s3 & st_r.cs_s2;
   assign sw_chg    = |(st_r.sw_s2 ^ st_r.sw_s3);
   // The shift register is read only after the select rise has passed
   // two flops; the link clock is idle then, so the word is stable.
   assign op_sleep  = is_op(lnk_r.shreg, OP_SLEEP);
   assign op_status = is_op(lnk_r.shreg, OP_STATUS);
   // The released line needs time to rise through its pull-up, so a low
   // level is not taken as a wake until the settle count has run out.
   assign line_low  = ~st_r.wk_s2 && (st_r.settle == 4'h0);

   // ----------------------------------------------------------------
   // Mode control
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt        = st_r;
      st_nxt.cs_s1  = spi_cs_n_i;
      st_nxt.cs_s2  = st_r.cs_s1;
      st_nxt.cs_s3  = st_r.cs_s2;
      st_nxt.wk_s1  = wake_n_i;
      st_nxt.wk_s2  = st_r.wk_s1;
      st_nxt.sup_s1 = logic_supply_ok_i;
      st_nxt.sup_s2 = st_r.sup_s1;
      st_nxt.por_s1 = por_trip_i;
      st_nxt.por_s2 = st_r.por_s1;
      st_nxt.sw_s1  = {programmable_switch_input_i, ground_switch_input_i};
      st_nxt.sw_s2  = st_r.sw_s1;
      st_nxt.sw_s3  = st_r.sw_s2;

      if (cs_fall) begin
         st_nxt.race = 1'b0;
      end
      if (!st_r.cs_s2 && sw_chg) begin
         st_nxt.race = 1'b1;
      end
      if (st_r.settle != 4'h0) begin
         st_nxt.settle = st_r.settle - 4'h1;
      end

      if (cs_rise && op_status && st_r.mode == SPM_NORMAL) begin
         st_nxt.int_flag = 1'b0;
      end

      case (st_r.mode)
         SPM_NORMAL: begin
            if (cs_rise && op_sleep && !st_r.race && !sw_chg) begin
               st_nxt.mode   = SPM_SLEEP;
               st_nxt.settle = WAKE_SETTLE_CYC;
            end
         end
         SPM_SLEEP: begin
            if (sw_chg) begin
               st_nxt.mode     = SPM_NORMAL;
               st_nxt.int_flag = 1'b1;
               st_nxt.src      = SRC_SWITCH;
            end else if (line_low) begin
               st_nxt.mode     = SPM_NORMAL;
               st_nxt.int_flag = 1'b1;
               st_nxt.src      = SRC_LINE;
            end else if (st_r.sup_s2 && (cs_fall || (cs_rise && op_status))) begin
               st_nxt.mode     = SPM_NORMAL;
               st_nxt.int_flag = 1'b1;
               st_nxt.src      = SRC_SPI;
            end
         end
         default: begin
            st_nxt.mode = SPM_NORMAL;
         end
      endcase

      if (st_r.por_s2) begin
         st_nxt.mode     = SPM_NORMAL;
         st_nxt.race     = 1'b0;
         st_nxt.settle   = 4'h0;
         st_nxt.int_flag = 1'b0;
         st_nxt.src      = SRC_NONE;
      end

      st_nxt.sleep    = (st_nxt.mode == SPM_SLEEP);
      st_nxt.drv_oe_n = (st_nxt.mode == SPM_SLEEP);

      if (srst_i) begin
         st_nxt       = '0;
         st_nxt.mode  = SPM_NORMAL;
         // The select and wake synchronisers rest at the idle high level of
         // their pins, so no false select edge follows the end of reset.
         st_nxt.cs_s1 = 1'b1;
         st_nxt.cs_s2 = 1'b1;
         st_nxt.cs_s3 = 1'b1;
         st_nxt.wk_s1 = 1'b1;
         st_nxt.wk_s2 = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      st_r <= st_nxt;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // The wake pin is open drain: the data bit stays low and only the
   // enable decides whether the line is pulled down.
   assign wake_n_o    = 1'b0;
   assign wake_oe_n_o = st_r.drv_oe_n;
   assign sleep_o     = st_r.sleep;
   assign int_flag_o  = st_r.int_flag;
   assign wake_src_o  = st_r.src;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (srst_i);

   sequence s_sleeping;
      st_r.mode == SPM_SLEEP && !st_r.por_s2;
   endsequence

   sequence s_sleep_frame_end;
      st_r.mode == SPM_NORMAL && cs_rise && op_sleep && !st_r.por_s2;
   endsequence

   property p_cs_fall_wakes;
      s_sleeping and (cs_fall && st_r.sup_s2) |=> st_r.mode == SPM_NORMAL;
   endproperty
   a_cs_fall_wakes: assert property (p_cs_fall_wakes)
      else $error("select fall did not wake");

   property p_no_spi_wake_unpowered;
      s_sleeping and (!st_r.sup_s2 && !sw_chg && !line_low)
         |=> st_r.mode == SPM_SLEEP;
   endproperty
   a_no_spi_wake_unpowered: assert property (p_no_spi_wake_unpowered)
      else $error("woke by SPI without logic supply");

   property p_sleep_on_rise;
      s_sleep_frame_end and (!st_r.race && !sw_chg)
         |=> st_r.mode == SPM_SLEEP ##0 sleep_o && wake_oe_n_o;
   endproperty
   a_sleep_on_rise: assert property (p_sleep_on_rise)
      else $error("sleep command not taken");

   property p_sleep_only_on_own_frame;
      st_r.mode == SPM_NORMAL && !(cs_rise && op_sleep) && !st_r.por_s2
         |=> st_r.mode == SPM_NORMAL;
   endproperty
   a_sleep_only_on_own_frame: assert property (p_sleep_only_on_own_frame)
      else $error("sleep entered without own sleep frame");

   property p_wake_pin_follows_mode;
      wake_oe_n_o == (st_r.mode == SPM_SLEEP) && !wake_n_o;
   endproperty
   a_wake_pin_follows_mode: assert property (p_wake_pin_follows_mode)
      else $error("wake pin does not follow mode");

   property p_line_wakes;
      s_sleeping and (line_low && !sw_chg)
         |=> st_r.mode == SPM_NORMAL && st_r.src == SRC_LINE && !wake_oe_n_o;
   endproperty
   a_line_wakes: assert property (p_line_wakes)
      else $error("wake line did not wake");

   property p_race_stays_normal;
      s_sleep_frame_end and st_r.race |=> st_r.mode == SPM_NORMAL [*2];
   endproperty
   a_race_stays_normal: assert property (p_race_stays_normal)
      else $error("entered sleep despite switch change");

   property p_por_defaults;
      st_r.por_s2 |=> st_r.mode == SPM_NORMAL && !int_flag_o && wake_src_o == SRC_NONE;
   endproperty
   a_por_defaults: assert property (p_por_defaults)
      else $error("power-on reset did not restore defaults");

   property p_switch_wakes;
      s_sleeping and sw_chg
         |=> st_r.mode == SPM_NORMAL && !wake_oe_n_o && !sleep_o;
   endproperty
   a_switch_wakes: assert property (p_switch_wakes)
      else $error("switch change did not wake");

   property p_wake_source_flag;
      s_sleeping and sw_chg |=> int_flag_o && wake_src_o == SRC_SWITCH;
   endproperty
   a_wake_source_flag: assert property (p_wake_source_flag)
      else $error("wake source not recorded");

   property p_status_wakes;
      s_sleeping and (cs_rise && op_status && st_r.sup_s2)
         |=> st_r.mode == SPM_NORMAL ##1 !sleep_o;
   endproperty
   a_status_wakes: assert property (p_status_wakes)
      else $error("status command did not wake");

endmodule : spm_sleep_wake
`default_nettype wire

// >>> spm_host_model.sv
`default_nettype none
module spm_host_model (
   output var  logic sclk_o,
   output var  logic cs_n_o,
   output var  logic mosi_o,
   input  wire logic miso_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Frame master
   // ----------------------------------------------------------------
   logic [47:0] rx;

   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
      rx     = '0;
   end

   // The link clock runs only inside a frame, at a 48 ns period.
   task automatic xfer(input logic [47:0] data, input logic chain);
      int n;
      n = chain ? 48 : 24;
      cs_n_o = 1'b0;
      #100;
      for (int i = n - 1; i >= 0; i--) begin
         mosi_o = data[i];
         #24;
         rx = {rx[46:0], miso_i};
         sclk_o = 1'b1;
         #24;
         sclk_o = 1'b0;
      end
      #30;
      // A released data line must not keep its last value.
      mosi_o = ~mosi_o;
      cs_n_o = 1'b1;
      #400;
   endtask : xfer

endmodule : spm_host_model
`default_nettype wire

// >>> spm_sleep_wake_tb_top.sv
`default_nettype none
module spm_sleep_wake_tb_top import spm_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic              ref_clk_i, srst_i, sclk, cs_n, mosi, miso;
   logic [SW_G_W-1:0] gsw;
   logic [SW_P_W-1:0] psw;
   logic              wake_n_o, wake_oe_n_o, sup_ok, por, other_rel;
   logic              sleep_o, int_flag_o;
   logic [1:0]        wake_src_o, exp_w;
   logic              exp_f;
   logic [47:0]       word;
   int                seed = 20124;
   int                fail_count = 0;
   int                total_checks = 0;
   // The pull-up holds the shared line high unless someone pulls it low.
   wire logic         wake_line = (wake_oe_n_o ? 1'b1 : wake_n_o) & other_rel;

   spm_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));

   spm_sleep_wake dut (
      .ref_clk_i                   (ref_clk_i),
      .srst_i                      (srst_i),
      .spi_sclk_i                  (sclk),
      .spi_cs_n_i                  (cs_n),
      .spi_mosi_i                  (mosi),
      .spi_miso_o                  (miso),
      .ground_switch_input_i       (gsw),
      .programmable_switch_input_i (psw),
      .wake_n_i                    (wake_line),
      .wake_n_o                    (wake_n_o),
      .wake_oe_n_o                 (wake_oe_n_o),
      .logic_supply_ok_i           (sup_ok),
      .por_trip_i                  (por),
      .sleep_o                     (sleep_o),
      .int_flag_o                  (int_flag_o),
      .wake_src_o                  (wake_src_o)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   function automatic logic [23:0] frame(input logic [7:0] op);
      return {op, 16'($random(seed))};
   endfunction : frame

   task automatic settle_chk(input logic s);
      repeat (12) @(negedge ref_clk_i);
      check("sleep", 24'(sleep_o), 24'(s));
      check("wake_release", 24'(wake_oe_n_o), 24'(s));
      check("wake_data", 24'(wake_n_o), 24'h0);
      check("flag", 24'(int_flag_o), 24'(exp_f));
      check("source", 24'(wake_src_o), 24'(exp_w));
   endtask : settle_chk

   task automatic go_sleep;
      // Sleep is asked for with one unchained sleep frame, whether or not the switch state has been read back.
      host.xfer({24'h0, frame(OP_SLEEP)}, 1'b0);
      settle_chk(1'b1);
   endtask : go_sleep

   task automatic summarize;
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize

   // ----------------------------------------------------------------
   // Clock, watchdog and scenarios
   // ----------------------------------------------------------------
   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   // The whole sequence needs well under 2000 cycles.
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      fail_count++;
      summarize();
   end

   initial begin
      int k;
      srst_i = 1'b1;
      gsw = '0;
      psw = '0;
      sup_ok = 1'b1;
      por = 1'b0;
      other_rel = 1'b1;
      exp_f = 1'b0;
      exp_w = SRC_NONE;
      repeat (6) @(negedge ref_clk_i);
      srst_i = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      settle_chk(1'b0);
      word = {frame(OP_STATUS), frame(OP_SLEEP)};
      host.xfer(word, 1'b1);
      check("pass_through", host.rx[23:0], word[47:24]);
      settle_chk(1'b1);
      host.xfer({24'h0, frame(OP_STATUS)}, 1'b0);
      // The select fall wakes the device, and the status frame then read in
      // Normal clears the flag again, so only the source remains.
      exp_f = 1'b0;
      exp_w = SRC_SPI;
      settle_chk(1'b0);
      host.xfer({frame(OP_SLEEP), frame(OP_STATUS)}, 1'b1);
      exp_f = 1'b0;
      settle_chk(1'b0);
      for (int i = 0; i < 2; i++) begin
         go_sleep();
         k = $unsigned($random(seed)) % SW_G_W;
         if (i == 0)
            gsw[k] = ~gsw[k];
         else
            psw[k % SW_P_W] = ~psw[k % SW_P_W];
         exp_f = 1'b1;
         exp_w = SRC_SWITCH;
         settle_chk(1'b0);
      end
      go_sleep();
      other_rel = 1'b0;
      exp_w = SRC_LINE;
      settle_chk(1'b0);
      other_rel = 1'b1;
      // A switch that moves while the sleep frame is open must veto sleep.
      fork
         host.xfer({24'h0, frame(OP_SLEEP)}, 1'b0);
         begin
            repeat (15) @(negedge ref_clk_i);
            gsw[k] = ~gsw[k];
         end
      join
      settle_chk(1'b0);
      // After the race the host reads status once; that frame, taken in Normal,
      // clears the flag left by the line wake while the source stays SRC_LINE.
      host.xfer({24'h0, frame(OP_STATUS)}, 1'b0);
      exp_f = 1'b0;
      settle_chk(1'b0);
      go_sleep();
      sup_ok = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      host.xfer({24'h0, frame(OP_STATUS)}, 1'b0);
      settle_chk(1'b1);
      // Supply returns inside the frame, so only the status command can wake.
      fork
         host.xfer({24'h0, frame(OP_STATUS)}, 1'b0);
         begin
            repeat (15) @(negedge ref_clk_i);
            sup_ok = 1'b1;
         end
      join
      exp_f = 1'b1;
      exp_w = SRC_SPI;
      settle_chk(1'b0);
      sup_ok = 1'b1;
      por = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      por = 1'b0;
      exp_f = 1'b0;
      exp_w = SRC_NONE;
      settle_chk(1'b0);
      // A refresh frame after an unnoticed reset leaves the defaults intact.
      host.xfer({24'h0, frame(OP_STATUS)}, 1'b0);
      settle_chk(1'b0);
      summarize();
   end

endmodule : spm_sleep_wake_tb_top
`default_nettype wire
